// ### src/align_pkg.sv
// Shared constants and types for the phase-aligned serial link
// Summary of operation
// - Forwarded clock runs at eight times the bit rate
// - Eight equal phases reach every channel
// - Lock nearest phase, retime, feed deserializer
// - Phase choice automatic, continuous, per channel
// - Phase step is one eighth UI
// - Measure and correct phase each data transition
// - Lock on dense patterns, keep tracking drift
// - Transmitter sends ten zeros, ten ones
// - Transmitter sends 00001111 or 10010000 repeatedly
// - Transmitter sends alternating bits repeatedly
// - Each channel synchronizes words to global clock
// - Synchronizer FIFO four deep, word wide
// - Parallel clock writes, global clock reads; here the link clock writes, once per word
// - Global clock equals parallel clock frequency; here the global clock reads once every 160 cycles
// - No flags or enables; FIFO never overruns
// - Up to 1000 Mbps aligned, 840 without
// - One aligner PLL clocks twenty channels maximum
// - Word width ten bits
// - Parallel words delivered on global clock
package align_pkg;
	localparam int PHASE_COUNT = 8;
	localparam int WORD_W = 10;
	localparam int FIFO_DEPTH = 4;
	localparam int LINK_DIV = 2;
	localparam int MAX_CHANNELS = 20;
	localparam int RATE_ALIGNED_MBPS = 1000;
	localparam int RATE_PLAIN_MBPS = 840;
	localparam int UI_PS = 1000;
	localparam int STEP_PS = UI_PS / PHASE_COUNT;
	localparam int BIT_REF_CYCLES = LINK_DIV * PHASE_COUNT;
	localparam int WORD_REF_CYCLES = BIT_REF_CYCLES * WORD_W;
	localparam logic [2:0] HALF_UI = 3'h4;
	localparam logic [2:0] PHASE_ONE = 3'h1;
	localparam logic [2:0] PHASE_LAST = 3'h7;
	localparam logic [3:0] LAST_BIT = 4'(WORD_W - 1);
	localparam logic [3:0] BIT_LAST_REF = 4'(BIT_REF_CYCLES - 1);
	localparam logic [7:0] WORD_LAST_REF = 8'(WORD_REF_CYCLES - 1);
	localparam logic [4:0] LOCK_HITS = 5'h10;
	localparam logic [1:0] START_GAP = 2'h2;
	localparam logic [1:0] FIRST_WRITTEN = 2'h3;
	localparam logic [8:0] REPS_LAST = 9'h0FF;
	localparam logic [4:0] TEN_HALF = 5'h0A;
	localparam logic [4:0] TEN_LAST = 5'h13;
	localparam logic [4:0] BYTE_LAST = 5'h07;
	localparam logic [7:0] PAT_NIBBLE = 8'h0F;
	localparam logic [7:0] PAT_MARK = 8'h90;
	localparam logic [7:0] PAT_ALT = 8'hAA;

	typedef enum logic [1:0] {
		TRAIN_TEN = 2'b00,
		TRAIN_NIBBLE = 2'b01,
		TRAIN_MARK = 2'b10,
		TRAIN_ALT = 2'b11
	} train_mode_type;

	typedef enum logic {
		TX_DATA = 1'b0,
		TX_TRAIN = 1'b1
	} tx_state_type;

	typedef enum logic {
		ACQUIRE = 1'b0,
		LOCKED = 1'b1
	} lock_state_type;
endpackage : align_pkg

// ### src/serial_link_if.sv
// Forwarded clock and serial data between transmitter and receiver
interface serial_link_if;
	logic link_clk;
	logic serial_data;

	modport sender (output link_clk, output serial_data);
	modport receiver (input link_clk, input serial_data);
endinterface : serial_link_if

// ### src/phase_align_rx.sv
// Receiving end: phase tracker, deserializer and word synchronizer
module phase_align_rx
	import align_pkg::*;
(
	serial_link_if.receiver link,
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	output logic [WORD_W-1:0] rx_word_out,
	output logic rx_word_strobe_out,
	output logic rx_locked_out
);
	// Link-side state, clocked by the forwarded link clock
	typedef struct packed {
		logic ce_s1;
		logic ce_s2;
		logic din_s1;
		logic din_s2;
		logic prev_bit;
		logic [2:0] phase_cnt;
		logic [2:0] edge_ofs;
		logic [4:0] hits;
		lock_state_type lock;
		logic [WORD_W-1:0] shift;
		logic [3:0] bit_cnt;
		logic [1:0] wptr_bin;
		logic [1:0] wptr_gray;
		logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
	} link_state_type;

	// Global-side state, clocked by the global read clock
	typedef struct packed {
		logic [1:0] wg_s1;
		logic [1:0] wg_s2;
		logic lk_s1;
		logic lk_s2;
		logic started;
		logic [1:0] rptr;
		logic [7:0] cnt;
		logic [WORD_W-1:0] word;
		logic strobe;
		logic locked;
	} read_state_type;

	localparam link_state_type LINK_RESET = '{
		lock: ACQUIRE,
		wptr_bin: START_GAP,
		wptr_gray: {START_GAP[1], START_GAP[1] ^ START_GAP[0]},
		default: '0
	};
	localparam read_state_type READ_RESET = '{default: '0};

	link_state_type link_reg;
	link_state_type link_next;
	read_state_type read_reg;
	read_state_type read_next;
	logic [1:0] link_rst_reg;
	logic link_rst_n;
	logic [2:0] diff;
	logic edge_seen;
	logic [1:0] wsync_bin;

	// Reset release brought into the link domain
	always_ff @(posedge link.link_clk or negedge reset_n_in)
	begin
		if (!reset_n_in)
			link_rst_reg <= 2'h0;
		else
			link_rst_reg <= {link_rst_reg[0], 1'b1};
	end
	assign link_rst_n = link_rst_reg[1];

	// Phase error of the last transition against the tracked edge
	assign diff = link_reg.phase_cnt - link_reg.edge_ofs;
	assign edge_seen = link_reg.din_s2 != link_reg.prev_bit;

	// Link domain next state
	always_comb
	begin
		link_next = link_reg;
		link_next.ce_s1 = ce_in;
		link_next.ce_s2 = link_reg.ce_s1;
		link_next.din_s1 = link.serial_data;
		link_next.din_s2 = link_reg.din_s1;
		if (link_reg.ce_s2)
		begin
			// one bit spans eight link clock cycles
			link_next.phase_cnt = link_reg.phase_cnt + PHASE_ONE;
			link_next.prev_bit = link_reg.din_s2;
			if (edge_seen)
			begin
				if (diff == 3'h0)
				begin
					if (link_reg.hits != LOCK_HITS)
						link_next.hits = link_reg.hits + 5'h01;
				end
				else if (diff < HALF_UI)
				begin
					link_next.edge_ofs = link_reg.edge_ofs + PHASE_ONE;
					if (diff != PHASE_ONE)
						link_next.hits = 5'h00;
				end
				else if (diff > HALF_UI)
				begin
					link_next.edge_ofs = link_reg.edge_ofs - PHASE_ONE;
					if (diff != PHASE_LAST)
						link_next.hits = 5'h00;
				end
				else
				begin
					// Edge landed on the sample point: jump off it
					link_next.edge_ofs = link_reg.edge_ofs + PHASE_ONE;
					link_next.hits = 5'h00;
				end
			end
			// lock on dense data, keep tracking
			case (link_reg.lock)
				ACQUIRE:
				begin
					if (link_reg.hits == LOCK_HITS)
						link_next.lock = LOCKED;
				end
				LOCKED:
				begin
					if (link_next.hits == 5'h00)
						link_next.lock = ACQUIRE;
				end
				default:
				begin
					link_next.lock = ACQUIRE;
				end
			endcase
			if (link_reg.phase_cnt == link_reg.edge_ofs + HALF_UI)
			begin
				link_next.shift = {link_reg.shift[WORD_W-2:0], link_reg.din_s2};
				if (link_reg.bit_cnt == LAST_BIT)
				begin
					link_next.bit_cnt = 4'h0;
					link_next.mem[link_reg.wptr_bin] = link_next.shift;
					link_next.wptr_bin = link_reg.wptr_bin + 2'h1;
					link_next.wptr_gray = {link_next.wptr_bin[1],
						link_next.wptr_bin[1] ^ link_next.wptr_bin[0]};
				end
				else
				begin
					link_next.bit_cnt = link_reg.bit_cnt + 4'h1;
				end
			end
		end
	end

	// Link domain registers
	always_ff @(posedge link.link_clk or negedge link_rst_n)
	begin
		if (!link_rst_n)
			link_reg <= LINK_RESET;
		else
			link_reg <= link_next;
	end

	// Synchronized write pointer back in binary
	assign wsync_bin = {read_reg.wg_s2[1], read_reg.wg_s2[1] ^ read_reg.wg_s2[0]};

	// Global domain next state
	always_comb
	begin
		read_next = read_reg;
		read_next.wg_s1 = link_reg.wptr_gray;
		read_next.wg_s2 = read_reg.wg_s1;
		read_next.lk_s1 = link_reg.lock == LOCKED;
		read_next.lk_s2 = read_reg.lk_s1;
		read_next.strobe = 1'b0;
		if (ce_in)
		begin
			read_next.locked = read_reg.lk_s2;
			if (!read_reg.started)
			begin
				if (wsync_bin == FIRST_WRITTEN)
					read_next.started = 1'b1;
			end
			// word moved onto the global clock
			else if (read_reg.cnt == 8'h00)
			begin
				read_next.word = link_reg.mem[read_reg.rptr];
				read_next.strobe = 1'b1;
				read_next.rptr = read_reg.rptr + 2'h1;
				read_next.cnt = WORD_LAST_REF;
			end
			else
			begin
				read_next.cnt = read_reg.cnt - 8'h01;
			end
		end
	end

	// Global domain registers
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			read_reg <= READ_RESET;
		else
			read_reg <= read_next;
	end

	// Outputs straight from registers
	assign rx_word_out = read_reg.word;
	assign rx_word_strobe_out = read_reg.strobe;
	assign rx_locked_out = read_reg.locked;
endmodule : phase_align_rx

// ### src/phase_align_tx.sv
// Transmitting end: forwarded clock, training patterns, word serializer
module phase_align_tx
	import align_pkg::*;
(
	serial_link_if.sender link,
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic [WORD_W-1:0] tx_word_in,
	input wire logic train_start_in,
	input wire logic [1:0] train_mode_in,
	output logic tx_word_take_out,
	output logic train_busy_out
);
	// Whole transmitter state
	typedef struct packed {
		logic clk_div;
		logic [3:0] ref_cnt;
		logic [3:0] bit_cnt;
		logic [WORD_W-1:0] shift;
		tx_state_type st;
		train_mode_type mode;
		logic [4:0] pat_idx;
		logic [8:0] reps;
		logic serial;
		logic take;
	} tx_reg_type;

	localparam tx_reg_type TX_RESET = '{st: TX_DATA, mode: TRAIN_TEN, default: '0};

	tx_reg_type tx_reg;
	tx_reg_type tx_next;
	logic [4:0] pat_last;
	logic pat_bit;

	// Pattern length and current training bit
	always_comb
	begin
		pat_last = BYTE_LAST;
		pat_bit = 1'b0;
		case (tx_reg.mode)
			TRAIN_TEN:
			begin
				pat_last = TEN_LAST;
				pat_bit = tx_reg.pat_idx >= TEN_HALF;
			end
			TRAIN_NIBBLE: pat_bit = PAT_NIBBLE[3'(BYTE_LAST - tx_reg.pat_idx)];
			TRAIN_MARK: pat_bit = PAT_MARK[3'(BYTE_LAST - tx_reg.pat_idx)];
			TRAIN_ALT: pat_bit = PAT_ALT[3'(BYTE_LAST - tx_reg.pat_idx)];
			default: pat_bit = 1'b0;
		endcase
	end

	// Next state: divider, bit timing, training and data
	always_comb
	begin
		tx_next = tx_reg;
		tx_next.take = 1'b0;
		if (ce_in)
		begin
			tx_next.clk_div = ~tx_reg.clk_div;
			tx_next.ref_cnt = tx_reg.ref_cnt + 4'h1;
			if (train_start_in && tx_reg.st == TX_DATA)
			begin
				tx_next.st = TX_TRAIN;
				tx_next.mode = train_mode_type'(train_mode_in);
				tx_next.pat_idx = 5'h00;
				tx_next.reps = 9'h000;
			end
			else if (tx_reg.ref_cnt == BIT_LAST_REF)
			begin
				case (tx_reg.st)
					TX_TRAIN:
					begin
						tx_next.serial = pat_bit;
						tx_next.bit_cnt = 4'h0;
						if (tx_reg.pat_idx == pat_last)
						begin
							tx_next.pat_idx = 5'h00;
							tx_next.reps = tx_reg.reps + 9'h001;
							if (tx_reg.reps == REPS_LAST)
								tx_next.st = TX_DATA;
						end
						else
						begin
							tx_next.pat_idx = tx_reg.pat_idx + 5'h01;
						end
					end
					TX_DATA:
					begin
						if (tx_reg.bit_cnt == 4'h0)
						begin
							tx_next.serial = tx_word_in[WORD_W-1];
							tx_next.shift = {tx_word_in[WORD_W-2:0], 1'b0};
							tx_next.take = 1'b1;
						end
						else
						begin
							tx_next.serial = tx_reg.shift[WORD_W-1];
							tx_next.shift = {tx_reg.shift[WORD_W-2:0], 1'b0};
						end
						if (tx_reg.bit_cnt == LAST_BIT)
							tx_next.bit_cnt = 4'h0;
						else
							tx_next.bit_cnt = tx_reg.bit_cnt + 4'h1;
					end
					default: tx_next.st = TX_DATA;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			tx_reg <= TX_RESET;
		else
			tx_reg <= tx_next;
	end

	// Outputs straight from registers
	assign link.link_clk = tx_reg.clk_div;
	assign link.serial_data = tx_reg.serial;
	assign tx_word_take_out = tx_reg.take;
	assign train_busy_out = tx_reg.st == TX_TRAIN;
endmodule : phase_align_tx

// ### bench/serial_link_sva.sv
// Checker for the serial link and the user ports of both ends except the word and training mode ports
module serial_link_sva
(
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	input wire logic ce_in,
	input wire logic link_clk,
	input wire logic serial_data,
	input wire logic train_start_in,
	input wire logic tx_word_take_out,
	input wire logic train_busy_out,
	input wire logic rx_word_strobe_out,
	input wire logic rx_locked_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] age_reg;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	// Saturating count of cycles since reset release
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
		if (!reset_n_in)
			age_reg <= '0;
		else if (age_reg != 10'h3FF)
			age_reg <= age_reg + 10'h001;

	link_clk_toggle_a: assert property (age_reg > 10'h004 && $past(ce_in) |->
		link_clk != $past(link_clk)) else $error("link clock missed a toggle");
	bit_hold_a: assert property ($changed(serial_data) |=> $stable(serial_data)[*8])
		else $error("serial bit changed too early");
	take_pulse_a: assert property (tx_word_take_out |=> !tx_word_take_out[*8])
		else $error("word take pulse too long");
	take_gap_a: assert property (tx_word_take_out && !train_busy_out |->
		##160 (tx_word_take_out || train_busy_out)) else $error("word take spacing wrong");
	strobe_gap_a: assert property (rx_word_strobe_out |-> ##160 rx_word_strobe_out)
		else $error("read strobe spacing wrong");
	busy_start_a: assert property (train_start_in && !train_busy_out && ce_in |=> train_busy_out)
		else $error("training did not start");
	no_take_train_a: assert property (train_busy_out && $past(train_busy_out) |->
		!tx_word_take_out) else $error("word taken during training");
	lock_delay_a: assert property ($rose(rx_locked_out) |-> age_reg >= 10'h0F0)
		else $error("lock claimed too soon");
	link_freeze_a: assert property (!$past(ce_in) |-> $stable(link_clk))
		else $error("link clock ran while disabled");

	cover property ($rose(rx_locked_out));
	cover property ($fell(train_busy_out));
	cover property (!ce_in ##1 !ce_in);
	cover property (rx_word_strobe_out ##160 rx_word_strobe_out);
endmodule : serial_link_sva

// ### bench/tb.sv
// Bench joining transmitter and receiver across the serial link
module tb
	import align_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b1; // Starts high so the first reset is a real falling edge
	logic ce_in = 1'b1;
	logic [WORD_W-1:0] tx_word_in = 10'h0F1;
	logic train_start_in = 1'b0;
	logic [1:0] train_mode_in = 2'h0;
	logic tx_word_take_out, train_busy_out, rx_word_strobe_out, rx_locked_out;
	logic [WORD_W-1:0] rx_word_out;
	logic [39:0] bits;
	int mismatches = 0;
	int comparisons = 0;
	serial_link_if link_inst ();

	// Reference clock, 100 MHz
	// one clock, both ends
	always #5 ref_clk_in = ~ref_clk_in;

	// Both ends and the link checker
	phase_align_tx phase_align_tx_inst (.link(link_inst.sender), .ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in), .ce_in(ce_in), .tx_word_in(tx_word_in),
		.train_start_in(train_start_in), .train_mode_in(train_mode_in),
		.tx_word_take_out(tx_word_take_out), .train_busy_out(train_busy_out));
	phase_align_rx phase_align_rx_inst (.link(link_inst.receiver), .ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in), .ce_in(ce_in), .rx_word_out(rx_word_out),
		.rx_word_strobe_out(rx_word_strobe_out), .rx_locked_out(rx_locked_out));
	serial_link_sva serial_link_sva_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
		.ce_in(ce_in), .link_clk(link_inst.link_clk), .serial_data(link_inst.serial_data),
		.train_start_in(train_start_in), .tx_word_take_out(tx_word_take_out),
		.train_busy_out(train_busy_out), .rx_word_strobe_out(rx_word_strobe_out),
		.rx_locked_out(rx_locked_out));

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("ERROR at %0t: %s", $time, what);
		end
	endtask : check

	function automatic logic sel(input int which);
		case (which)
			0: sel = link_inst.serial_data;
			1: sel = tx_word_take_out;
			2: sel = rx_word_strobe_out;
			default: sel = !train_busy_out;
		endcase
	endfunction : sel

	// Bounded wait for a line change (0) or a high level of a flag
	task automatic wait_on(input int which, input int limit, output int n);
		logic first;
		first = sel(0);
		n = 0;
		do
		begin
			@(negedge ref_clk_in);
			n++;
		end
		while (n < limit && (which == 0 ? sel(0) === first : sel(which) !== 1'b1));
		if (n >= limit)
		begin
			check(1'b0, "wait timed out");
			tally_and_finish();
		end
	endtask : wait_on

	// Sample the line in the middle of each bit after an edge
	task automatic capture(input int count);
		int n;
		wait_on(0, 400, n);
		repeat (8) @(negedge ref_clk_in);
		for (int i = 0; i < count; i++)
		begin
			bits[i] = link_inst.serial_data;
			repeat (16) @(negedge ref_clk_in);
		end
	endtask : capture

	function automatic logic rot_ok(input logic [19:0] pat, input int len, input int count);
		logic hit;
		rot_ok = 1'b0;
		for (int r = 0; r < len; r++)
		begin
			hit = 1'b1;
			for (int i = 0; i < count; i++)
				if (bits[i] !== pat[len - 1 - (i + r) % len])
					hit = 1'b0;
			rot_ok |= hit;
		end
	endfunction : rot_ok

	task automatic apply_reset;
		@(negedge ref_clk_in);
		reset_n_in = 1'b0;
		repeat (8) @(negedge ref_clk_in);
		check({link_inst.link_clk, link_inst.serial_data, tx_word_take_out, train_busy_out,
			rx_word_strobe_out, rx_locked_out, rx_word_out} === '0, "reset state");
		reset_n_in = 1'b1;
	endtask : apply_reset

	// Hold the clock enable low after reset, then watch the first two reads
	task automatic freeze_and_gap;
		int n;
		apply_reset();
		ce_in = 1'b0;
		pulse_start(2'h3);
		repeat (20) @(negedge ref_clk_in);
		check({link_inst.link_clk, link_inst.serial_data, tx_word_take_out, train_busy_out,
			rx_word_strobe_out} === 5'h00, "clock enable did not freeze");
		ce_in = 1'b1;
		wait_on(2, 400, n);
		check(rx_word_out === '0, "first read not a reset entry");
		wait_on(2, 400, n);
		check(n == 160 && rx_word_out === '0, "second read not a reset entry");
	endtask : freeze_and_gap

	task automatic pulse_start(input logic [1:0] mode);
		train_mode_in = mode;
		train_start_in = 1'b1;
		@(negedge ref_clk_in);
		train_start_in = 1'b0;
	endtask : pulse_start

	task automatic train_pattern(input logic [1:0] mode, input logic [19:0] pat, input int len);
		apply_reset();
		pulse_start(mode);
		check(train_busy_out === 1'b1, "busy missing after start");
		capture(2 * len);
		check(rot_ok(pat, len, 2 * len), "training pattern wrong");
	endtask : train_pattern

	task automatic full_run;
		int n;
		train_pattern(2'h0, 20'h003FF, 20);
		pulse_start(2'h1);
		capture(40);
		check(rot_ok(20'h003FF, 20, 40), "start while busy not ignored");
		wait_on(3, 90000, n);
		check(rx_locked_out === 1'b1, "no lock after training");
		wait_on(1, 400, n);
		wait_on(1, 400, n);
		check(n == 160, "word take spacing");
		repeat (4) wait_on(2, 400, n);
		for (int k = 0; k < 3; k++)
		begin
			wait_on(2, 400, n);
			check(n == 160, "read strobe spacing");
			for (int i = 0; i < 20; i++)
				bits[i] = rx_word_out[9 - i % 10];
			check(rot_ok({10'h000, tx_word_in}, 10, 20), "received word wrong");
		end
	endtask : full_run

	// Main sequence
	initial
	begin
		freeze_and_gap();
		train_pattern(2'h1, 20'h0000F, 8);
		train_pattern(2'h2, 20'h00090, 8);
		train_pattern(2'h3, 20'h000AA, 8);
		full_run();
		tally_and_finish();
	end
endmodule : tb
